// ===== inc/msd_pkg.sv
`default_nettype none
package msd_pkg;

  // Register map (byte addresses)
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFS_FILTER_CFG = 8'h20;
  localparam logic [7:0]  OFS_INPUT_CTRL = 8'h24;
  localparam logic [7:0]  OFS_STATUS     = 8'h28;

  // filter_chain_config fields
  localparam int          CFG_W          = 24;
  localparam logic [23:0] CFG_RESET      = 24'h000000;
  localparam logic [23:0] CFG_WMASK      = 24'h1F7773;
  localparam int          CH_LSB         = 0;
  localparam int          RATE_LSB       = 4;
  localparam int          SEL_LSB        = 8;
  localparam int          GAINCOR_BIT    = 12;
  localparam int          OFSCOR_BIT     = 13;
  localparam int          OFSCAL_BIT     = 14;
  localparam int          SENS_LSB       = 16;

  // input_ctrl and status fields
  localparam int          CTRL_RATE256_BIT = 0;
  localparam logic        CTRL_RESET       = 1'b0;
  localparam int          STAT_MASK_LSB    = 0;
  localparam int          STAT_CHEN_LSB    = 8;
  localparam int          STAT_RATE_BIT    = 16;
  localparam int          STAT_GAIN_LSB    = 24;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Filter structure
  localparam int NUM_CH          = 4;
  localparam int NUM_STAGES      = 5;
  localparam int OUT_W           = 24;
  localparam int ACC_W           = 40;
  localparam int FIRST_SINC_SECTION_ORDER     = 5;
  localparam int FIRST_SINC_SECTION_RATIO     = 8;
  localparam int FIRST_SINC_SECTION_GAIN_BITS = 15;
  localparam int SECOND_SINC_SECTION_ORDER [NUM_STAGES] = '{4, 4, 4, 5, 6};
  localparam int SECOND_SINC_SECTION_RATIO [NUM_STAGES] = '{2, 3, 2, 2, 2};
  localparam int SECOND_SINC_SECTION_GAIN  [NUM_STAGES] = '{4, 7, 4, 5, 6};

  // Stage masks, bit 0 is stage 1
  localparam logic [4:0] MASK_5    = 5'h10;
  localparam logic [4:0] MASK_45   = 5'h18;
  localparam logic [4:0] MASK_345  = 5'h1C;
  localparam logic [4:0] MASK_245  = 5'h1A;
  localparam logic [4:0] MASK_1345 = 5'h1D;

  typedef enum logic [2:0] {
    OS_SINC = 3'h0, OS_FIR1 = 3'h1, OS_FIR2 = 3'h2, OS_IIR1 = 3'h3,
    OS_IIR2 = 3'h4, OS_IIR3 = 3'h5, OS_RSV6 = 3'h6, OS_RSV7 = 3'h7
  } msd_out_sel_t;

endpackage
`default_nettype wire

// ===== src/msd_sinc_decimator.sv
// Operation
// - First section is a fixed fifth-order sinc decimating by eight per channel.
// - First section takes 512 kHz one-bit streams, yields 64 kHz samples.
// - A 256 kHz stream is oversampled to run with 512 kHz settings.
// - First section weights span 36 taps, a fifth-power sinc of length eight.
// - Second section ratios 2,4,8,12,16 by cascading chosen stages.
// - Second-section ratio follows output rate and output stage only.
// - Every enabled channel runs the identical filter hardware.
// - Each channel outputs a 24-bit two's-complement word downstream.
// - Stage one: fourth-order sinc, decimate by two, weights 1,4,6,4,1.
// - Stage two: fourth-order sinc, decimate by three.
// - Stage three: fourth-order sinc, decimate by two.
// - Stage four: fifth-order sinc, decimate by two.
// - Stage five: sixth-order sinc, decimate by two.
// - First-FIR output: rate codes 7..3 pick the listed stage sets.
// - Second-FIR or IIR output: rate codes 7..2 pick listed stage sets.
// - Align pulse restarts decimation phase with the pulse as time zero.
// - Align resets pointers only; stored data kept, mixing old and new.
// - Channel field: 00 four, 01 one, 10 two, 11 three channels.
//
// Chosen here: the AXI4-Lite register port.
`default_nettype none

// One integrate-and-dump sinc stage, order and ratio as parameters
module msd_cic_stage #(
  parameter int ORDER = 4,
  parameter int RATIO = 2,
  parameter int W     = 40
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                align,
  input  wire logic                in_valid,
  input  wire logic signed [W-1:0] in_data,
  output logic                     out_valid,
  output logic signed [W-1:0]      out_data
);
  localparam int             PW   = $clog2(RATIO);
  localparam logic [PW-1:0]  LAST = PW'(RATIO - 1);

  logic signed [W-1:0] integ_q [ORDER];
  logic signed [W-1:0] comb_q  [ORDER];
  logic signed [W-1:0] c       [ORDER+1];
  logic [PW-1:0]       phase_q;
  logic                dump;

  assign dump = in_valid && !align && (phase_q == LAST);

  // Integrator cascade; data survives an align
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < ORDER; k++) integ_q[k] <= '0;
    end else if (in_valid) begin
      integ_q[0] <= integ_q[0] + in_data;
      for (int k = 1; k < ORDER; k++) integ_q[k] <= integ_q[k] + integ_q[k-1];
    end
  end

  // Decimation phase, restarted by align
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= '0;
    end else if (align) begin
      phase_q <= '0;
    end else if (in_valid) begin
      phase_q <= (phase_q == LAST) ? '0 : phase_q + 1'b1;
    end
  end

  // Comb cascade at the decimated rate
  always_comb begin
    c[0] = integ_q[ORDER-1];
    for (int k = 0; k < ORDER; k++) c[k+1] = c[k] - comb_q[k];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < ORDER; k++) comb_q[k] <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= dump;
      if (dump) begin
        for (int k = 0; k < ORDER; k++) comb_q[k] <= c[k];
        out_data <= c[ORDER];
      end
    end
  end
endmodule

module msd_sinc_decimator (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [msd_pkg::ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [msd_pkg::ADDR_W-1:0]          s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire logic                                mod_bit_clk,
  input  wire logic [msd_pkg::NUM_CH-1:0]          mod_bit_data,
  input  wire logic                                filter_align_pulse,
  output logic [msd_pkg::NUM_CH*msd_pkg::OUT_W-1:0] sinc_word,
  output logic [msd_pkg::NUM_CH-1:0]               sinc_valid,
  output logic [2:0]                               output_stage_select,
  output logic                                     offset_calibration_enable,
  output logic                                     offset_correction_enable,
  output logic                                     gain_correction_enable,
  output logic [4:0]                               calibration_sensitivity
);
  import msd_pkg::*;

  logic [CFG_W-1:0]  cfg_q;
  logic              rate256_q;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q, wdata_q, rd_val, merged;
  logic [3:0]        wstrb_q;
  logic [ADDR_W-1:0] waddr_q;
  logic              wr_fire, wr_hit, rd_hit;
  logic [2:0]        bclk_s_q, align_s_q;
  logic [NUM_CH-1:0] data_s1_q, data_s2_q, bit_q;
  logic              tick_q, align_q;
  logic [4:0]        mask_q;
  logic [5:0]        gain_q;
  logic [NUM_CH-1:0] chen_q;
  logic [NUM_CH-1:0]                  valid_q;
  logic [NUM_CH-1:0][OUT_W-1:0]       word_q;
  wire  signed [ACC_W-1:0]            fin_d [NUM_CH];
  wire                                fin_v [NUM_CH];

  // Stage set chosen from output stage and output rate
  function automatic logic [4:0] stage_mask(input logic [2:0] sel,
                                            input logic [2:0] rate);
    logic [4:0] m;
    m = MASK_1345;
    if (sel == OS_FIR1) begin
      unique case (rate)
        3'h7:    m = MASK_45;
        3'h6:    m = MASK_345;
        3'h5:    m = MASK_1345;
        3'h4:    m = MASK_345;
        3'h3:    m = MASK_245;
        default: m = MASK_1345;
      endcase
    end else if (sel >= OS_FIR2 && sel <= OS_IIR3) begin
      unique case (rate)
        3'h7:    m = MASK_5;
        3'h6:    m = MASK_45;
        3'h5:    m = MASK_345;
        3'h4:    m = MASK_1345;
        3'h3:    m = MASK_245;
        3'h2:    m = MASK_345;
        default: m = MASK_1345;
      endcase
    end
    return m;
  endfunction

  // Total gain in bits of the active cascade
  function automatic logic [5:0] gain_bits(input logic [4:0] m);
    int g;
    g = FIRST_SINC_SECTION_GAIN_BITS;
    for (int i = 0; i < NUM_STAGES; i++) if (m[i]) g += SECOND_SINC_SECTION_GAIN[i];
    return 6'(g);
  endfunction

  // Scale full scale to 24 bits and saturate
  function automatic logic [OUT_W-1:0] sat_word(
      input logic signed [ACC_W-1:0] v, input logic [5:0] g);
    logic signed [ACC_W+7:0] wide;
    logic [5:0]              shamt;
    shamt = g - 6'h0F;
    wide  = $signed({v, 8'h00}) >>> shamt;
    if (wide > 48'sh7FFFFF) return 24'h7FFFFF;
    else if (wide < -48'sh800000) return 24'h800000;
    else return wide[OUT_W-1:0];
  endfunction

  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign wr_hit  = (waddr_q == OFS_FILTER_CFG) || (waddr_q == OFS_INPUT_CTRL);
  assign rd_hit  = (s_axi_araddr == OFS_FILTER_CFG) ||
                   (s_axi_araddr == OFS_INPUT_CTRL) ||
                   (s_axi_araddr == OFS_STATUS);

  // Byte-lane merge of the held write data onto the addressed register
  always_comb begin
    merged = (waddr_q == OFS_FILTER_CFG) ? {8'h00, cfg_q}
                                         : {31'h0, rate256_q};
    for (int b = 0; b < 4; b++) if (wstrb_q[b]) merged[8*b +: 8] = wdata_q[8*b +: 8];
  end

  // Read data mux
  always_comb begin
    rd_val = 32'h0;
    if (s_axi_araddr == OFS_FILTER_CFG) rd_val = {8'h00, cfg_q};
    else if (s_axi_araddr == OFS_INPUT_CTRL) rd_val[CTRL_RATE256_BIT] = rate256_q;
    else if (s_axi_araddr == OFS_STATUS) begin
      rd_val[STAT_MASK_LSB +: 5] = mask_q;
      rd_val[STAT_CHEN_LSB +: NUM_CH] = chen_q;
      rd_val[STAT_RATE_BIT] = rate256_q;
      rd_val[STAT_GAIN_LSB +: 6] = gain_q;
    end
  end

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      waddr_q   <= '0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        waddr_q   <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Register storage; reserved bits held at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q     <= CFG_RESET;
      rate256_q <= CTRL_RESET;
    end else if (wr_fire) begin
      if (waddr_q == OFS_FILTER_CFG)
        cfg_q <= merged[CFG_W-1:0] & CFG_WMASK;
      if (waddr_q == OFS_INPUT_CTRL)
        rate256_q <= merged[CTRL_RATE256_BIT];
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_val;
      rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // Pin synchronisers; third bit only for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bclk_s_q  <= 3'h0;
      align_s_q <= 3'h0;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      bclk_s_q  <= {bclk_s_q[1:0], mod_bit_clk};
      align_s_q <= {align_s_q[1:0], filter_align_pulse};
      data_s1_q <= mod_bit_data;
      data_s2_q <= data_s1_q;
    end
  end

  // Bit capture on rising edge; 256 kHz also ticks on falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_q   <= '0;
      tick_q  <= 1'b0;
      align_q <= 1'b0;
    end else begin
      if (bclk_s_q[1] && !bclk_s_q[2]) bit_q <= data_s2_q;
      tick_q  <= (bclk_s_q[1] && !bclk_s_q[2]) ||
                 (rate256_q && !bclk_s_q[1] && bclk_s_q[2]);
      align_q <= align_s_q[1] && !align_s_q[2];
    end
  end

  // Configuration decode into cascade and channel selections
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= MASK_1345;
      gain_q <= gain_bits(MASK_1345);
      chen_q <= '1;
    end else begin
      mask_q <= stage_mask(cfg_q[SEL_LSB +: 3], cfg_q[RATE_LSB +: 3]);
      gain_q <= gain_bits(stage_mask(cfg_q[SEL_LSB +: 3],
                                     cfg_q[RATE_LSB +: 3]));
      unique case (cfg_q[CH_LSB +: 2])
        2'h0: chen_q <= 4'hF;
        2'h1: chen_q <= 4'h1;
        2'h2: chen_q <= 4'h3;
        2'h3: chen_q <= 4'h7;
      endcase
    end
  end

  // One identical filter chain per channel
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    wire signed [ACC_W-1:0] sd [NUM_STAGES+1];
    wire                    sv [NUM_STAGES+1];
    logic signed [ACC_W-1:0] in_pm;

    assign in_pm = bit_q[ch] ? ACC_W'(1) : -ACC_W'(1);

    msd_cic_stage #(
      .ORDER (FIRST_SINC_SECTION_ORDER),
      .RATIO (FIRST_SINC_SECTION_RATIO),
      .W     (ACC_W)
    ) u_first_sinc_section (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .align     (align_q),
      .in_valid  (tick_q && chen_q[ch]),
      .in_data   (in_pm),
      .out_valid (sv[0]),
      .out_data  (sd[0])
    );

    // Second section: skipped stages pass samples straight through
    for (genvar st = 0; st < NUM_STAGES; st++) begin : g_st
      logic                    st_v;
      logic signed [ACC_W-1:0] st_d;

      msd_cic_stage #(
        .ORDER (SECOND_SINC_SECTION_ORDER[st]),
        .RATIO (SECOND_SINC_SECTION_RATIO[st]),
        .W     (ACC_W)
      ) u_second_sinc_section (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .align     (align_q),
        .in_valid  (sv[st] && mask_q[st]),
        .in_data   (sd[st]),
        .out_valid (st_v),
        .out_data  (st_d)
      );

      assign sv[st+1] = mask_q[st] ? st_v : sv[st];
      assign sd[st+1] = mask_q[st] ? st_d : sd[st];
    end

    assign fin_v[ch] = sv[NUM_STAGES];
    assign fin_d[ch] = sd[NUM_STAGES];
  end

  // Output words, one-cycle valid per produced sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_q <= '0;
      word_q  <= '0;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        valid_q[ch] <= fin_v[ch] && chen_q[ch];
        if (fin_v[ch]) word_q[ch] <= sat_word(fin_d[ch], gain_q);
      end
    end
  end

  assign s_axi_awready             = awready_q;
  assign s_axi_wready              = wready_q;
  assign s_axi_bvalid              = bvalid_q;
  assign s_axi_bresp               = bresp_q;
  assign s_axi_arready             = arready_q;
  assign s_axi_rvalid              = rvalid_q;
  assign s_axi_rdata               = rdata_q;
  assign s_axi_rresp               = rresp_q;
  assign sinc_word                 = word_q;
  assign sinc_valid                = valid_q;
  assign output_stage_select       = cfg_q[SEL_LSB +: 3];
  assign offset_calibration_enable = cfg_q[OFSCAL_BIT];
  assign offset_correction_enable  = cfg_q[OFSCOR_BIT];
  assign gain_correction_enable    = cfg_q[GAINCOR_BIT];
  assign calibration_sensitivity   = cfg_q[SENS_LSB +: 5];
endmodule
`default_nettype wire

// ===== verif/msd_sinc_decimator_asserts.sv
`default_nettype none
module msd_sinc_chk (
  input wire logic                                   aclk,
  input wire logic                                   aresetn,
  input wire logic                                   s_axi_awvalid,
  input wire logic                                   s_axi_awready,
  input wire logic                                   s_axi_wvalid,
  input wire logic                                   s_axi_wready,
  input wire logic [1:0]                             s_axi_bresp,
  input wire logic                                   s_axi_bvalid,
  input wire logic                                   s_axi_bready,
  input wire logic                                   s_axi_arvalid,
  input wire logic                                   s_axi_arready,
  input wire logic [31:0]                            s_axi_rdata,
  input wire logic                                   s_axi_rvalid,
  input wire logic                                   s_axi_rready,
  input wire logic [msd_pkg::NUM_CH*msd_pkg::OUT_W-1:0] sinc_word,
  input wire logic [msd_pkg::NUM_CH-1:0]             sinc_valid,
  input wire logic [2:0]                             output_stage_select,
  input wire logic                                   gain_correction_enable,
  input wire logic [4:0]                             calibration_sensitivity
);
  timeunit 1ns;
  timeprecision 1ps;
  import msd_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data taken together, and a read taken
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // Register bus answer timing and holding
  wr_resp_a: assert property (
    wr_take |=> (!s_axi_awready && !s_axi_bvalid) ##1 s_axi_bvalid)
    else $error("write answer late or early");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rd_resp_a: assert property (
    rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  cfg_upd_a: assert property (
    $changed({output_stage_select, gain_correction_enable,
              calibration_sensitivity}) |-> $rose(s_axi_bvalid))
    else $error("config outputs moved without a write");

  // Output stream shape
  ch_set_a: assert property (
    sinc_valid inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("channel pulse set not contiguous");
  pulse_gap_a: assert property (
    sinc_valid[0] |=> !sinc_valid[0] [*8])
    else $error("output pulses too close");
  word_new_a: assert property (
    $changed(sinc_word) |-> sinc_valid != 4'h0)
    else $error("output word changed without pulse");
endmodule
`default_nettype wire

// ===== verif/msd_mod_model.sv
`default_nettype none
module msd_mod_model #(
  parameter int HALF_PS = 22300
) (
  input  wire logic       run,
  input  wire logic [3:0] level,
  output logic            bit_clk,
  output logic [3:0]      bits,
  output int              ticks
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bit clock runs while enabled; data moves on the falling edge
  initial begin
    bit_clk = 1'b0;
    bits = 4'h5;
    ticks = 0;
    forever begin
      if (run) begin
        #(HALF_PS * 1ps) bit_clk = 1'b1;
        ticks = ticks + 1;
        #(HALF_PS * 1ps) bit_clk = 1'b0;
        bits = level;
      end else begin
        #4;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/msd_sinc_decimator_tb_top.sv
`default_nettype none
module msd_sinc_decimator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import msd_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, filter_align_pulse, run;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, mod_bit_clk, offset_calibration_enable;
  logic        offset_correction_enable, gain_correction_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [2:0]  output_stage_select;
  logic [3:0]  s_axi_wstrb, level, mod_bit_data, sinc_valid;
  logic [4:0]  calibration_sensitivity;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [95:0] sinc_word;
  int          bad_count, total_checks, tk, tk0;

  msd_sinc_decimator i_msd_sinc_decimator (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mod_bit_clk, .mod_bit_data,
    .filter_align_pulse, .sinc_word, .sinc_valid, .output_stage_select,
    .offset_calibration_enable, .offset_correction_enable,
    .gain_correction_enable, .calibration_sensitivity);
  msd_mod_model i_msd_mod_model (.run, .level, .bit_clk(mod_bit_clk),
    .bits(mod_bit_data), .ticks(tk));

  // Clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [95:0] seen, exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 40000) begin
      chk(1'b0, 1'b1, "wait ran out");
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input int lag = 0);
    int   n;
    logic aw, w;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    while (!(aw && w) && n < 40000) begin
      @(posedge aclk);
      n++;
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Optional late ready so the answer has to stand
    repeat (lag) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 40000);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask

  task automatic axr(input logic [7:0] a, input int lag = 0);
    int   n;
    logic t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    t = 1'b0;
    n = 0;
    while (!t && n < 40000) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) begin
        t = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    repeat (lag) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 40000);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask

  // Expected second-section stage set for output stage and rate
  function automatic logic [4:0] emask(input logic [2:0] fs, dr);
    logic [4:0] f1 [8] = '{5'h1D, 5'h1D, 5'h1D, 5'h1A, 5'h1C, 5'h1D, 5'h1C,
                           5'h18};
    logic [4:0] f2 [8] = '{5'h1D, 5'h1D, 5'h1C, 5'h1A, 5'h1D, 5'h1C, 5'h18,
                           5'h10};
    if (fs == 3'h1)
      return f1[dr];
    if (fs >= 3'h2 && fs <= 3'h5)
      return f2[dr];
    return 5'h1D;
  endfunction

  function automatic int ratio(input logic [4:0] m);
    int r;
    r = 8 * (m[0] ? 2 : 1) * (m[1] ? 3 : 1) * (m[2] ? 2 : 1);
    return r * (m[3] ? 2 : 1) * (m[4] ? 2 : 1);
  endfunction

  task automatic pulse();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (sinc_valid == 4'h0 && n < 40000);
    tmo(n);
  endtask

  task automatic t_regs();
    axr(8'h20);
    chk(rd, 32'h0, "config reset value");
    axr(8'h28);
    chk(rd, 32'h2200_0F1D, "status after reset");
    axr(8'h2C, 3);
    chk({rs, rd}, {RESP_SLVERR, 32'h0}, "unmapped read");
    wr(8'h28, 32'hFFFF_FFFF, 3);
    chk(rs, RESP_SLVERR, "status write refused");
    wr(8'h20, 32'hFFFF_FFFF);
    chk(rs, RESP_OKAY, "config write taken");
    axr(8'h20);
    chk(rd, 32'h001F_7773, "reserved bits read zero");
    chk({output_stage_select, offset_calibration_enable,
         offset_correction_enable, gain_correction_enable,
         calibration_sensitivity}, 11'h7FF, "config fields");
  endtask

  task automatic t_table();
    logic [3:0] cm [4] = '{4'hF, 4'h1, 4'h3, 4'h7};
    logic [2:0] fs, dr;
    for (int i = 0; i < 64; i++) begin
      fs = i[5:3];
      dr = i[2:0];
      wr(8'h20, {21'h0, fs, 1'b0, dr, 2'h0, dr[1:0]});
      axr(8'h28);
      chk(rd[4:0], emask(fs, dr), "stage set");
      chk(rd[11:8], cm[dr[1:0]], "channel set");
    end
  endtask

  task automatic t_rate(input logic [2:0] fs, dr);
    int n;
    wr(8'h20, {21'h0, fs, 1'b0, dr, 4'h0});
    // Find a bit clock rise, then align clear of the next one
    tk0 = tk;
    n = 0;
    while (tk == tk0 && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    repeat (7) @(posedge aclk);
    filter_align_pulse <= 1'b1;
    tk0 = tk;
    repeat (2) @(posedge aclk);
    filter_align_pulse <= 1'b0;
    pulse();
    chk(tk - tk0, ratio(emask(fs, dr)), "first after align");
    tk0 = tk;
    pulse();
    chk(tk - tk0, ratio(emask(fs, dr)), "output spacing");
  endtask

  task automatic t_full();
    wr(8'h20, 32'h0000_0270);
    level <= 4'hF;
    repeat (12) pulse();
    chk(sinc_valid, 4'hF, "all channels pulse");
    chk(sinc_word, {4{24'h7FFFFF}}, "full scale high");
    level <= 4'h0;
    repeat (12) pulse();
    chk(sinc_word, {4{24'h800000}}, "full scale low");
    wr(8'h20, 32'h0000_0271);
    repeat (2) pulse();
    chk(sinc_valid, 4'h1, "one channel only");
  endtask

  task automatic t_256();
    wr(8'h24, 32'h1);
    axr(8'h28);
    chk(rd[16], 1'b1, "slow input mode shown");
    repeat (2) pulse();
    tk0 = tk;
    pulse();
    chk(tk - tk0, 8, "slow input spacing");
  endtask

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, filter_align_pulse, run} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    level = 4'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_table();
    run <= 1'b1;
    level <= 4'hA;
    t_rate(3'h2, 3'h7);
    t_rate(3'h2, 3'h3);
    t_rate(3'h1, 3'h7);
    t_rate(3'h0, 3'h7);
    t_full();
    t_256();
    summarize();
  end
endmodule

bind msd_sinc_decimator msd_sinc_chk i_msd_sinc_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sinc_word,
  .sinc_valid, .output_stage_select, .gain_correction_enable,
  .calibration_sensitivity);
`default_nettype wire
